// ===== inc/fdsf_map.svh
`ifndef FDSF_MAP_SVH
`define FDSF_MAP_SVH

`define FDSF_FRAME_BITS 16
`define FDSF_MANT_BITS 10
`define FDSF_EXP_BITS 3
`define FDSF_SR_BITS 13
`define FDSF_MANT_LSB 0
`define FDSF_EXP_LSB 10
`define FDSF_LEVEL_BITS 18
`define FDSF_LEVEL_FRAC 7
`define FDSF_CNT_BITS 8
`define FDSF_MANT_RST 10'h000
`define FDSF_EXP_RST 3'h0
`define FDSF_LEVEL_RST 18'h00000
`define FDSF_CNT_RST 8'h00
`define FDSF_CNT_MAX 8'hff

`endif

// ===== inc/fdsf_pkg.sv
`include "fdsf_map.svh"

package fdsf_pkg;
  typedef logic [`FDSF_MANT_BITS-1:0] fdsf_mant_t;
  typedef logic [`FDSF_EXP_BITS-1:0] fdsf_exp_t;
  typedef logic signed [`FDSF_LEVEL_BITS-1:0] fdsf_level_t;
  typedef logic [`FDSF_CNT_BITS-1:0] fdsf_cnt_t;
  typedef enum logic [0:0] {FDSF_EMPTY, FDSF_HOLD} fdsf_state_t;
endpackage

// ===== inc/fdsf_shift_if.sv
`include "fdsf_map.svh"

interface fdsf_shift_if #(
  parameter int WIDTH = `FDSF_SR_BITS
);
  logic shift_en;
  logic bit_in;
  logic [WIDTH-1:0] word;

  modport ctrl (
    output shift_en,
    output bit_in,
    input word
  );

  modport store (
    input shift_en,
    input bit_in,
    output word
  );
endinterface

// ===== hw/fdsf_shift.sv
`include "fdsf_map.svh"

module fdsf_shift
  import fdsf_pkg::*;
#(
  parameter int WIDTH = `FDSF_SR_BITS
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  fdsf_shift_if.store sh
);

  logic [WIDTH-1:0] word_q;
  logic [WIDTH-1:0] word_d;

  // New bits enter at the top, so the oldest bits of a long frame simply fall off the bottom.
  always_comb
  begin
    word_d = word_q;
    if (sh.shift_en)
    begin
      word_d = {sh.bit_in, word_q[WIDTH-1:1]};
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      word_q <= '0;
    end
    else
    begin
      word_q <= word_d;
    end
  end

  assign sh.word = word_q;

  shift_capture_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    sh.shift_en |=> word_q[WIDTH-1] == $past(sh.bit_in))
    else $error("Serial bit not captured at the top of the shift register.");

  old_bits_drop_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    sh.shift_en |=> word_q[WIDTH-2:0] == $past(word_q[WIDTH-1:1]))
    else $error("Shift register did not move older bits down by one.");

endmodule

// ===== hw/fdsf_top.sv
// Summary of operation
// - Shift serial input on each rising clock.
// - Strobe falling edge latches word, starts conversion.
// - First three bits of a frame ignored.
// - Next ten bits are mantissa, LSB first.
// - Last three bits exponent N, scale 2^-N.
// - Mantissa offset code, half-LSB added, bipolar.
// - Frame length varies; only ignored lead changes.
`include "fdsf_map.svh"

module fdsf_top
  import fdsf_pkg::*;
#(
  parameter int SR_BITS = `FDSF_SR_BITS
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic serial_clk_in,
  input wire logic serial_sample_in,
  input wire logic word_strobe_in,
  output logic conv_start,
  output logic sample_valid,
  output fdsf_mant_t mantissa_out,
  output fdsf_exp_t exponent_out,
  output logic polarity_out,
  output fdsf_level_t level_out,
  output logic exponent_illegal,
  output fdsf_cnt_t frame_len_out,
  output logic short_frame
);

  fdsf_shift_if #(.WIDTH(SR_BITS)) sh ();

  logic clk_prev_q;
  logic clk_prev_d;
  logic strobe_prev_q;
  logic strobe_prev_d;
  logic clk_rise;
  logic strobe_fall;

  fdsf_mant_t mant_q;
  fdsf_mant_t mant_d;
  fdsf_exp_t exp_q;
  fdsf_exp_t exp_d;
  fdsf_level_t level_q;
  fdsf_level_t level_d;
  logic start_q;
  logic start_d;
  logic illegal_q;
  logic illegal_d;
  fdsf_state_t state_q;
  fdsf_state_t state_d;

  fdsf_cnt_t cnt_q;
  fdsf_cnt_t cnt_d;
  fdsf_cnt_t len_q;
  fdsf_cnt_t len_d;
  logic short_q;
  logic short_d;

  fdsf_mant_t word_mant;
  fdsf_exp_t word_exp;
  logic signed [`FDSF_MANT_BITS:0] offset_code;

  // Inputs arrive synchronous to clk_sys, so edges are found against the previous sample only.
  always_comb
  begin
    clk_prev_d = serial_clk_in;
    strobe_prev_d = word_strobe_in;
    clk_rise = serial_clk_in && !clk_prev_q;
    strobe_fall = !word_strobe_in && strobe_prev_q;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      clk_prev_q <= 1'b0;
      strobe_prev_q <= 1'b0;
    end
    else
    begin
      clk_prev_q <= clk_prev_d;
      strobe_prev_q <= strobe_prev_d;
    end
  end

  assign sh.shift_en = clk_rise;
  assign sh.bit_in = serial_sample_in;

  fdsf_shift #(
    .WIDTH(SR_BITS)
  ) u_shift (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .sh(sh)
  );

  // Only the last thirteen bits before the strobe are ever kept, whatever the frame length.
  always_comb
  begin
    word_mant = sh.word[`FDSF_EXP_LSB-1:`FDSF_MANT_LSB];
    word_exp = sh.word[SR_BITS-1:`FDSF_EXP_LSB];
    offset_code = {~word_mant[`FDSF_MANT_BITS-1], word_mant[`FDSF_MANT_BITS-2:0], 1'b1};
  end

  // A serial edge in the same cycle as the strobe fall belongs to the next frame, so the
  // pre-shift word is latched.
  always_comb
  begin
    mant_d = mant_q;
    exp_d = exp_q;
    level_d = level_q;
    illegal_d = illegal_q;
    state_d = state_q;
    start_d = strobe_fall;
    if (strobe_fall)
    begin
      mant_d = word_mant;
      exp_d = word_exp;
      level_d = $signed({offset_code, {`FDSF_LEVEL_FRAC{1'b0}}}) >>> word_exp;
      illegal_d = (word_exp == `FDSF_EXP_RST);
      state_d = FDSF_HOLD;
    end
    case (state_q)
      FDSF_EMPTY:
      begin
        if (strobe_fall)
        begin
          state_d = FDSF_HOLD;
        end
      end
      FDSF_HOLD:
      begin
        state_d = FDSF_HOLD;
      end
      default:
      begin
        state_d = FDSF_EMPTY;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      mant_q <= `FDSF_MANT_RST;
      exp_q <= `FDSF_EXP_RST;
      level_q <= `FDSF_LEVEL_RST;
      illegal_q <= 1'b0;
      start_q <= 1'b0;
      state_q <= FDSF_EMPTY;
    end
    else
    begin
      mant_q <= mant_d;
      exp_q <= exp_d;
      level_q <= level_d;
      illegal_q <= illegal_d;
      start_q <= start_d;
      state_q <= state_d;
    end
  end

  // The bit count is diagnostic only; it saturates rather than wraps on a stuck strobe.
  always_comb
  begin
    cnt_d = cnt_q;
    len_d = len_q;
    short_d = short_q;
    if (clk_rise && cnt_q != `FDSF_CNT_MAX)
    begin
      cnt_d = cnt_q + 8'h01;
    end
    if (strobe_fall)
    begin
      len_d = cnt_q;
      short_d = (cnt_q < 8'(SR_BITS));
      cnt_d = clk_rise ? 8'h01 : `FDSF_CNT_RST;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cnt_q <= `FDSF_CNT_RST;
      len_q <= `FDSF_CNT_RST;
      short_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      len_q <= len_d;
      short_q <= short_d;
    end
  end

  assign conv_start = start_q;
  assign sample_valid = (state_q == FDSF_HOLD);
  assign mantissa_out = mant_q;
  assign exponent_out = exp_q;
  assign polarity_out = mant_q[`FDSF_MANT_BITS-1];
  assign level_out = level_q;
  assign exponent_illegal = illegal_q;
  assign frame_len_out = len_q;
  assign short_frame = short_q;

  logic last_bit_q;
  logic last_bit_d;

  // Keeps the most recent serial bit so the strobe alignment check has an independent witness.
  always_comb
  begin
    last_bit_d = last_bit_q;
    if (clk_rise)
    begin
      last_bit_d = serial_sample_in;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      last_bit_q <= 1'b0;
    end
    else
    begin
      last_bit_q <= last_bit_d;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence strobe_drop_s;
    strobe_prev_q && !word_strobe_in;
  endsequence

  sequence latched_s;
    ##1 conv_start;
  endsequence

  latch_on_fall_a: assert property (strobe_drop_s |-> latched_s)
    else $error("No conversion start after strobe fell.");

  mant_capture_a: assert property (strobe_drop_s |=> mantissa_out == $past(sh.word[9:0]))
    else $error("Mantissa not taken from the ten bits before the exponent.");

  exp_capture_a: assert property (strobe_drop_s |=> exponent_out == $past(sh.word[12:10]))
    else $error("Exponent not taken from the last three bits.");

  strobe_aligned_a: assert property (conv_start |-> exponent_out[2] == $past(last_bit_q))
    else $error("Exponent top bit is not the last bit before the strobe.");

  polarity_level_a: assert property (conv_start && exponent_out == 3'h1 |->
    level_out[17] == !mantissa_out[9] && level_out != 18'h00000)
    else $error("Level polarity disagrees with mantissa top bit.");

  hold_value_a: assert property (!strobe_fall |=> $stable(mantissa_out) && $stable(exponent_out))
    else $error("Latched sample changed without a strobe fall.");

endmodule

// ===== test/fdsf_sender.sv
module fdsf_sender
(
  input wire logic clk_sys,
  output logic serial_clk_in,
  output logic serial_sample_in,
  output logic word_strobe_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // The bit clock rests low between frames; the strobe rests high.
  initial
  begin
    serial_clk_in = 1'b0;
    serial_sample_in = 1'b0;
    word_strobe_in = 1'b1;
  end

  // Bits go out oldest first, so the exponent ends the frame.
  task automatic send(input logic [31:0] w, input int n);
    repeat (2) @(negedge clk_sys);
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk_sys);
      serial_clk_in = 1'b0;
      serial_sample_in = w[i];
      @(negedge clk_sys);
      serial_clk_in = 1'b1;
    end
    @(negedge clk_sys);
    serial_clk_in = 1'b0;
    serial_sample_in = ~serial_sample_in;
    word_strobe_in = 1'b0;
    @(negedge clk_sys);
    word_strobe_in = 1'b1;
  endtask
endmodule

// ===== test/floating_dac_serial_frontend_bench.sv
module floating_dac_serial_frontend_bench
  import fdsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {fdsf_mant_t m; fdsf_exp_t e; int n;} fdsf_row_t;
  logic clk_sys, sys_rst, serial_clk_in, serial_sample_in, word_strobe_in;
  logic conv_start, sample_valid, polarity_out, exponent_illegal, short_frame;
  fdsf_mant_t mantissa_out;
  fdsf_exp_t exponent_out;
  fdsf_level_t level_out;
  fdsf_cnt_t frame_len_out;
  int n_mismatch = 0;
  int checks_done = 0;
  logic [12:0] sr_m;
  fdsf_cnt_t len_m;
  logic [31:0] w;
  // The last row breaks the exponent rule on purpose: exponent 0 raises exponent_illegal.
  fdsf_row_t rows [8] = '{'{10'h000, 3'h1, 16}, '{10'h3ff, 3'h7, 16}, '{10'h200, 3'h4, 13},
    '{10'h155, 3'h2, 20}, '{10'h1ff, 3'h3, 14}, '{10'h2aa, 3'h5, 17}, '{10'h0f0, 3'h6, 16},
    '{10'h30c, 3'h0, 16}};

  fdsf_top #(.SR_BITS(13)) u_fdsf_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .serial_clk_in(serial_clk_in),
    .serial_sample_in(serial_sample_in), .word_strobe_in(word_strobe_in), .conv_start(conv_start),
    .sample_valid(sample_valid), .mantissa_out(mantissa_out), .exponent_out(exponent_out),
    .polarity_out(polarity_out), .level_out(level_out), .exponent_illegal(exponent_illegal),
    .frame_len_out(frame_len_out), .short_frame(short_frame));

  fdsf_sender u_fdsf_sender (.clk_sys(clk_sys), .serial_clk_in(serial_clk_in),
    .serial_sample_in(serial_sample_in), .word_strobe_in(word_strobe_in));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk1(string nm, logic x, logic g);
    checks_done++;
    if (g !== x)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic chkv(string nm, logic [17:0] x, logic [17:0] g);
    checks_done++;
    if (g !== x)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic check_all();
    fdsf_mant_t m;
    fdsf_exp_t e;
    logic signed [17:0] v;
    m = sr_m[9:0];
    e = sr_m[12:10];
    v = ($signed({8'h00, m}) * 2 + 1 - 1024) * 128;
    v = v >>> e;
    chk1("conv_start", 1'b1, conv_start);
    chkv("mantissa", 18'(m), 18'(mantissa_out));
    chkv("exponent", 18'(e), 18'(exponent_out));
    chk1("polarity", m[9], polarity_out);
    chkv("level", v, level_out);
    chk1("illegal", e == 3'h0, exponent_illegal);
    chkv("frame_len", 18'(len_m), 18'(frame_len_out));
    chk1("short", len_m < 13, short_frame);
    chk1("valid", 1'b1, sample_valid);
  endtask

  // The bench keeps its own copy of the last 13 bits to predict stale fill.
  task automatic frame(logic [31:0] fw, int n);
    for (int i = 0; i < n; i++)
      sr_m = {fw[i], sr_m[12:1]};
    len_m = n > 255 ? 8'hff : 8'(n);
    // The sender returns half a cycle after the latch edge, while the one-cycle start pulse still stands.
    u_fdsf_sender.send(fw, n);
    check_all();
    @(negedge clk_sys);
    chk1("conv_start", 1'b0, conv_start);
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    stop_test();
  end

  initial
  begin
    sys_rst = 1'b1;
    sr_m = 13'h0000;
    repeat (6) @(negedge clk_sys);
    chk1("valid", 1'b0, sample_valid);
    chkv("level", 18'h00000, level_out);
    sys_rst = 1'b0;
    foreach (rows[i])
    begin
      w = ({19'h0, rows[i].e, rows[i].m} << (rows[i].n - 13)) | (32'h55555555 & ((32'h1 << (rows[i].n - 13)) - 1));
      frame(w, rows[i].n);
    end
    repeat (6) @(negedge clk_sys);
    chkv("mantissa", 18'(sr_m[9:0]), 18'(mantissa_out));
    chk1("conv_start", 1'b0, conv_start);
    frame(32'h0000001f, 5);
    frame(32'h00000000, 0);
    sys_rst = 1'b1;
    @(negedge clk_sys);
    sys_rst = 1'b0;
    chk1("valid", 1'b0, sample_valid);
    chkv("mantissa", 18'h00000, 18'(mantissa_out));
    sr_m = 13'h0000;
    frame(32'h0000a5c3, 16);
    stop_test();
  end
endmodule
